// file: rtl/pri_pkg.sv
// proximity readout package: command codes, field positions, reset values, timing
// assumes a 50 MHz system clock and a host on a two-wire command bus
package pri_pkg;

	// ********************************
	// command codes
	// ********************************
	localparam logic [7:0] CMD_CONF2 = 8'h03;
	localparam logic [7:0] CMD_THDL  = 8'h05;
	localparam logic [7:0] CMD_THDH  = 8'h06;
	localparam logic [7:0] CMD_CONF4 = 8'h08;
	localparam logic [7:0] CMD_COUNT = 8'hf8;
	localparam logic [7:0] CMD_FLAGS = 8'hf9;
	localparam logic [7:0] CMD_IDENT = 8'hfa;
	localparam logic [7:0] CMD_CAL   = 8'hfb;
	localparam logic [6:0] BUS_ADDR  = 7'h60;

	// ********************************
	// field positions
	// ********************************
	localparam int MODE_LSB    = 2;
	localparam int PERS_LSB    = 4;
	localparam int CAL_IRQ_BIT = 0;
	localparam int LP_EN_BIT   = 8;
	localparam int LP_PER_LSB  = 9;
	localparam int FLAG_CAL    = 13;
	localparam int FLAG_PROT   = 12;
	localparam int FLAG_NEAR   = 9;
	localparam int FLAG_FAR    = 8;
	localparam int CAL_BUSY    = 15;
	localparam int CAL_SUN     = 14;

	// ********************************
	// reset values and identity
	// ********************************
	localparam logic [15:0] CONF2_RESET = 16'h0000;
	localparam logic [15:0] CONF4_RESET = 16'h0000;
	localparam logic [11:0] THD_RESET   = 12'h000;
	localparam logic [7:0]  DEVICE_CODE = 8'h5a; // arbitrary value
	localparam logic [3:0]  VERSION     = 4'h1;  // arbitrary value
	localparam logic [1:0]  ADDR_OPTION = 2'h0;

	// ********************************
	// timing
	// ********************************
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned LP_BASE_MS     = 40;
	localparam int unsigned LP_BASE_CYCLES = LP_BASE_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		MODE_OFF   = 2'b00,
		MODE_LEVEL = 2'b01,
		MODE_FIRST = 2'b10,
		MODE_NORM  = 2'b11
	} pri_mode_type;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_ADDR  = 8'h02,
		ST_AACK  = 8'h04,
		ST_CMD   = 8'h08,
		ST_CACK  = 8'h10,
		ST_WDATA = 8'h20,
		ST_WACK  = 8'h40,
		ST_RDATA = 8'h80
	} pri_state_type;

endpackage

// file: rtl/pri_line_if.sv
// two-wire line events carried from the pin synchroniser to the command engine
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface pri_line_if;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	modport src (output sda, output scl_rise, output scl_fall, output start, output stop);
	modport dst (input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface

// file: rtl/pri_pin_sync.sv
// synchroniser and edge finder for the two-wire pins
// assumes the pins are asynchronous to the system clock
`timescale 1ns/1ps
module pri_pin_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_rstn,
	input  wire logic i_scl,
	input  wire logic i_sda,
	pri_line_if.src   line
);
	logic [1:0] meta;
	logic [1:0] sync;
	logic [1:0] prev;

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta <= 2'h3;
			sync <= 2'h3;
			prev <= 2'h3;
		end
		else
		begin
			meta <= {i_scl, i_sda};
			sync <= meta;
			prev <= sync;
		end
	end

	// bit 1 is the clock line, bit 0 the data line
	assign line.sda      = sync[0];
	assign line.scl_rise = sync[1] & ~prev[1];
	assign line.scl_fall = ~sync[1] & prev[1];
	assign line.start    = sync[1] & prev[1] & prev[0] & ~sync[0];
	assign line.stop     = sync[1] & prev[1] & ~prev[0] & sync[0];
endmodule

// file: rtl/pri_lp_timer.sv
// low-power measurement period generator
// assumes a one-cycle tick is enough to start one measurement
`timescale 1ns/1ps
module pri_lp_timer #(
	parameter int unsigned P_BASE_CYCLES = pri_pkg::LP_BASE_CYCLES
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_enable,
	input  wire logic [1:0] i_period,
	output logic            o_tick
);
	logic [31:0] base;
	logic [2:0]  mult;
	logic [31:0] next_base;
	logic [2:0]  next_mult;
	logic        next_tick;
	logic        base_end;

	// period is base times 1, 2, 4 or 8
	always_comb
	begin
		base_end  = (base == P_BASE_CYCLES - 1);
		next_base = base_end ? 32'h0 : base + 32'h1;
		next_mult = base_end ? mult + 3'h1 : mult;
		next_tick = base_end && (mult == 3'((4'h1 << i_period) - 4'h1));
		if (next_tick)
			next_mult = 3'h0;
		if (!i_enable)
		begin
			next_base = 32'h0;
			next_mult = 3'h0;
			next_tick = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			base   <= 32'h0;
			mult   <= 3'h0;
			o_tick <= 1'b0;
		end
		else
		begin
			base   <= next_base;
			mult   <= next_mult;
			o_tick <= next_tick;
		end
	end
endmodule

// file: rtl/pri_readout.sv
// proximity result readout, event flags and interrupt pin behind a two-wire command bus
// assumes the measuring core delivers counts and calibration status on the system clock
`timescale 1ns/1ps

module pri_readout #(
	parameter int unsigned P_LP_BASE_CYCLES = pri_pkg::LP_BASE_CYCLES
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	output logic             o_int_out,
	output logic             o_int_oe,
	input  wire logic        i_meas_valid,
	input  wire logic [11:0] i_meas_count,
	input  wire logic        i_cal_busy,
	input  wire logic        i_cal_done,
	input  wire logic        i_cal_sun,
	input  wire logic [11:0] i_cal_data,
	input  wire logic        i_protect_entry,
	output logic             o_meas_start
);
	pri_line_if line ();

	pri_pin_sync u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_scl     (i_scl),
		.i_sda     (i_sda),
		.line      (line.src)
	);

	logic [15:0] conf4;

	pri_lp_timer #(
		.P_BASE_CYCLES (P_LP_BASE_CYCLES)
	) u_timer (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_enable  (conf4[pri_pkg::LP_EN_BIT]),
		.i_period  (conf4[pri_pkg::LP_PER_LSB +: 2]),
		.o_tick    (o_meas_start)
	);

	// ********************************
	// read decode
	// ********************************
	logic [15:0] conf2;
	logic [11:0] thdl;
	logic [11:0] thdh;
	logic [11:0] count;
	logic [15:0] flags;
	logic [11:0] cal_data;
	logic        cal_sun;
	logic        cal_busy_d;

	function automatic logic [15:0] read_word(input logic [7:0] code);
		case (code)
			pri_pkg::CMD_CONF2: read_word = conf2;
			pri_pkg::CMD_THDL:  read_word = {4'h0, thdl};
			pri_pkg::CMD_THDH:  read_word = {4'h0, thdh};
			pri_pkg::CMD_CONF4: read_word = conf4;
			pri_pkg::CMD_COUNT: read_word = {4'h0, count};
			pri_pkg::CMD_FLAGS: read_word = flags;
			pri_pkg::CMD_IDENT: read_word = {2'h0, pri_pkg::ADDR_OPTION,
				pri_pkg::VERSION, pri_pkg::DEVICE_CODE};
			pri_pkg::CMD_CAL:   read_word = {i_cal_busy, cal_sun, 2'h0, cal_data};
			default:            read_word = 16'h0000;
		endcase
	endfunction

	// ********************************
	// command engine
	// ********************************
	pri_pkg::pri_state_type state;
	pri_pkg::pri_state_type next_state;
	logic [3:0]  bitc;
	logic [3:0]  next_bitc;
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic [7:0]  cmd;
	logic [7:0]  next_cmd;
	logic [7:0]  wlow;
	logic [7:0]  next_wlow;
	logic [15:0] rword;
	logic [15:0] next_rword;
	logic        byte_hi;
	logic        next_byte_hi;
	logic        rw;
	logic        next_rw;
	logic        ack_phase;
	logic        next_ack_phase;
	logic        next_sda_oe;
	logic        wr_pulse;
	logic        rd_pulse;

	always_comb
	begin
		next_state     = state;
		next_bitc      = bitc;
		next_shreg     = shreg;
		next_cmd       = cmd;
		next_wlow      = wlow;
		next_rword     = rword;
		next_byte_hi   = byte_hi;
		next_rw        = rw;
		next_ack_phase = ack_phase;
		next_sda_oe    = o_sda_oe;
		wr_pulse       = 1'b0;
		rd_pulse       = 1'b0;
		if (line.start)
		begin
			next_state  = pri_pkg::ST_ADDR;
			next_bitc   = 4'h0;
			next_sda_oe = 1'b0;
		end
		else if (line.stop)
		begin
			next_state  = pri_pkg::ST_IDLE;
			next_sda_oe = 1'b0;
		end
		else if (line.scl_rise)
		begin
			if (state == pri_pkg::ST_RDATA)
			begin
				if (ack_phase)
					next_rw = ~line.sda; // host acknowledged, keep reading
			end
			else if (state == pri_pkg::ST_ADDR || state == pri_pkg::ST_CMD ||
				state == pri_pkg::ST_WDATA)
			begin
				next_shreg = {shreg[6:0], line.sda};
				next_bitc  = bitc + 4'h1;
			end
		end
		else if (line.scl_fall)
		begin
			case (state)
				pri_pkg::ST_ADDR:
					if (bitc == 4'h8)
					begin
						if (shreg[7:1] == pri_pkg::BUS_ADDR)
						begin
							next_state  = pri_pkg::ST_AACK;
							next_rw     = shreg[0];
							next_sda_oe = 1'b1;
						end
						else
							next_state = pri_pkg::ST_IDLE;
					end
				pri_pkg::ST_CMD:
					if (bitc == 4'h8)
					begin
						next_state   = pri_pkg::ST_CACK;
						next_cmd     = shreg;
						next_byte_hi = 1'b0;
						next_sda_oe  = 1'b1;
					end
				pri_pkg::ST_WDATA:
					if (bitc == 4'h8)
					begin
						next_state  = pri_pkg::ST_WACK;
						next_sda_oe = 1'b1;
						if (byte_hi)
							wr_pulse = 1'b1;
						else
							next_wlow = shreg;
					end
				pri_pkg::ST_AACK:
					if (rw)
					begin
						// whole word latched so both bytes belong together
						next_rword     = read_word(cmd);
						rd_pulse       = 1'b1;
						next_byte_hi   = 1'b0;
						next_state     = pri_pkg::ST_RDATA;
						next_sda_oe    = ~next_rword[7];
						next_shreg     = {next_rword[6:0], 1'b0};
						next_bitc      = 4'h1;
						next_ack_phase = 1'b0;
					end
					else
					begin
						next_state  = pri_pkg::ST_CMD;
						next_bitc   = 4'h0;
						next_sda_oe = 1'b0;
					end
				pri_pkg::ST_CACK, pri_pkg::ST_WACK:
				begin
					if (state == pri_pkg::ST_WACK)
						next_byte_hi = ~byte_hi;
					next_state  = pri_pkg::ST_WDATA;
					next_bitc   = 4'h0;
					next_sda_oe = 1'b0;
				end
				pri_pkg::ST_RDATA:
					if (ack_phase)
					begin
						next_ack_phase = 1'b0;
						if (rw)
						begin
							next_byte_hi = ~byte_hi;
							rd_pulse     = byte_hi;
							if (byte_hi)
								next_rword = read_word(cmd);
							next_shreg  = byte_hi ? {next_rword[6:0], 1'b0} : {rword[14:8], 1'b0};
							next_sda_oe = byte_hi ? ~next_rword[7] : ~rword[15];
							next_bitc   = 4'h1;
						end
						else
							next_state = pri_pkg::ST_IDLE;
					end
					else if (bitc == 4'h8)
					begin
						next_sda_oe    = 1'b0;
						next_ack_phase = 1'b1;
					end
					else
					begin
						next_sda_oe = ~shreg[7];
						next_shreg  = {shreg[6:0], 1'b0};
						next_bitc   = bitc + 4'h1;
					end
				default: next_state = pri_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state     <= pri_pkg::ST_IDLE;
			bitc      <= 4'h0;
			shreg     <= 8'h00;
			cmd       <= 8'h00;
			wlow      <= 8'h00;
			rword     <= 16'h0000;
			byte_hi   <= 1'b0;
			rw        <= 1'b0;
			ack_phase <= 1'b0;
			o_sda_oe  <= 1'b0;
			o_sda_out <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			bitc      <= next_bitc;
			shreg     <= next_shreg;
			cmd       <= next_cmd;
			wlow      <= next_wlow;
			rword     <= next_rword;
			byte_hi   <= next_byte_hi;
			rw        <= next_rw;
			ack_phase <= next_ack_phase;
			o_sda_oe  <= next_sda_oe;
			o_sda_out <= 1'b0;
		end
	end

	// ********************************
	// threshold and persistence
	// ********************************
	pri_pkg::pri_mode_type mode;
	logic [2:0] pers_len;
	logic [1:0] hit;
	logic [1:0] persist;
	logic [2:0] run [2];

	assign mode     = pri_pkg::pri_mode_type'(conf2[pri_pkg::MODE_LSB +: 2]);
	assign pers_len = {1'b0, conf2[pri_pkg::PERS_LSB +: 2]} + 3'h1;
	// level mode switches on reaching the upper threshold
	assign hit[1] = (mode == pri_pkg::MODE_LEVEL) ? (i_meas_count >= thdh)
		: (i_meas_count > thdh);
	assign hit[0] = i_meas_count < thdl;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_pers
			logic [2:0] next_run;
			always_comb
			begin
				next_run = run[g];
				if (i_meas_valid)
					next_run = !hit[g] ? 3'h0 : (run[g] == pers_len) ? run[g] : run[g] + 3'h1;
				persist[g] = i_meas_valid && hit[g] && (next_run == pers_len);
			end
			always_ff @(posedge i_sys_clk or negedge i_rstn)
			begin
				if (!i_rstn)
					run[g] <= 3'h0;
				else
					run[g] <= next_run;
			end
		end
	endgenerate

	// ********************************
	// events, flags and interrupt pin
	// ********************************
	logic        near_state;
	logic        seen;
	logic        int_level;
	logic        close_ev;
	logic        far_ev;
	logic        next_near;
	logic        next_seen;
	logic        next_level;
	logic [15:0] set_bits;
	logic [15:0] irq_mask;
	logic [15:0] next_flags;
	logic [15:0] next_conf2;
	logic [15:0] next_conf4;
	logic [11:0] next_thdl;
	logic [11:0] next_thdh;
	logic [11:0] next_count;
	logic [11:0] next_cal_data;
	logic        next_cal_sun;
	logic        next_int_oe;
	logic        latched;

	always_comb
	begin
		latched  = (mode == pri_pkg::MODE_FIRST) || (mode == pri_pkg::MODE_NORM);
		// inside the band neither edge fires; only crossings do, plus the first far result in normal mode
		close_ev = latched && persist[1] && !near_state;
		far_ev   = latched && persist[0] && (near_state ||
			(mode == pri_pkg::MODE_NORM && !seen));
		next_near  = close_ev ? 1'b1 : far_ev ? 1'b0 : near_state;
		next_seen  = seen | close_ev | far_ev;
		next_level = int_level;
		if (mode != pri_pkg::MODE_LEVEL)
			next_level = 1'b0;
		else if (persist[1])
			next_level = 1'b1;
		else if (persist[0])
			next_level = 1'b0;
		set_bits = 16'h0000;
		set_bits[pri_pkg::FLAG_CAL]  = i_cal_done;
		set_bits[pri_pkg::FLAG_PROT] = i_protect_entry;
		set_bits[pri_pkg::FLAG_NEAR] = close_ev;
		set_bits[pri_pkg::FLAG_FAR]  = far_ev;
		irq_mask = 16'h0000;
		irq_mask[pri_pkg::FLAG_CAL]  = conf4[pri_pkg::CAL_IRQ_BIT];
		irq_mask[pri_pkg::FLAG_NEAR] = 1'b1;
		irq_mask[pri_pkg::FLAG_FAR]  = 1'b1;
		// a new event in the clearing cycle survives
		next_flags = ((rd_pulse && cmd == pri_pkg::CMD_FLAGS) ? 16'h0000 : flags)
			| set_bits;
		next_int_oe = (mode == pri_pkg::MODE_LEVEL) ? next_level
			: |(next_flags & irq_mask);
		next_conf2 = conf2;
		next_conf4 = conf4;
		next_thdl  = thdl;
		next_thdh  = thdh;
		if (wr_pulse)
			case (cmd)
				pri_pkg::CMD_CONF2: next_conf2 = {shreg, wlow};
				pri_pkg::CMD_THDL:  next_thdl  = {shreg[3:0], wlow};
				pri_pkg::CMD_THDH:  next_thdh  = {shreg[3:0], wlow};
				pri_pkg::CMD_CONF4: next_conf4 = {shreg, wlow};
				default: ;
			endcase
		next_count    = i_meas_valid ? i_meas_count : count;
		next_cal_data = i_cal_done ? i_cal_data : cal_data;
		next_cal_sun  = (i_cal_busy && !cal_busy_d) ? 1'b0
			: (cal_sun | (i_cal_busy & i_cal_sun));
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			conf2      <= pri_pkg::CONF2_RESET;
			conf4      <= pri_pkg::CONF4_RESET;
			thdl       <= pri_pkg::THD_RESET;
			thdh       <= pri_pkg::THD_RESET;
			count      <= 12'h000;
			flags      <= 16'h0000;
			cal_data   <= 12'h000;
			cal_sun    <= 1'b0;
			cal_busy_d <= 1'b0;
			near_state <= 1'b0;
			seen       <= 1'b0;
			int_level  <= 1'b0;
			o_int_oe   <= 1'b0;
			o_int_out  <= 1'b0;
		end
		else
		begin
			conf2      <= next_conf2;
			conf4      <= next_conf4;
			thdl       <= next_thdl;
			thdh       <= next_thdh;
			count      <= next_count;
			flags      <= next_flags;
			cal_data   <= next_cal_data;
			cal_sun    <= next_cal_sun;
			cal_busy_d <= i_cal_busy;
			near_state <= next_near;
			seen       <= next_seen;
			int_level  <= next_level;
			o_int_oe   <= next_int_oe;
			o_int_out  <= 1'b0;
		end
	end
endmodule

// file: verification/pri_host_model.sv
// host side of the two-wire command bus: open-drain bit and word transfers
// assumes a pull-up on the data line, resolved by the bench
`timescale 1ns/1ps
module pri_host_model #(
	parameter int P_QUARTER = 5
) (
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic wait_q(input int n);
		repeat (n * P_QUARTER) @(posedge i_sys_clk);
	endtask
	task automatic start_cond();
		wait_q(1);
		o_sda_low <= 1'b0;
		wait_q(1);
		o_scl <= 1'b1;
		wait_q(2);
		o_sda_low <= 1'b1;
		wait_q(2);
		o_scl <= 1'b0;
	endtask
	task automatic stop_cond();
		wait_q(1);
		o_sda_low <= 1'b1;
		wait_q(1);
		o_scl <= 1'b1;
		wait_q(2);
		o_sda_low <= 1'b0;
		wait_q(2);
	endtask
	task automatic bit_io(input logic b, output logic r);
		wait_q(1);
		o_sda_low <= !b;
		wait_q(1);
		o_scl <= 1'b1;
		wait_q(2);
		r = i_sda;
		o_scl <= 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, ack);
	endtask
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] w, output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		start_cond();
		byte_io({pri_pkg::BUS_ADDR, 1'b0}, 1'b1, q, a[0]);
		byte_io(cmd, 1'b1, q, a[1]);
		byte_io(w[7:0], 1'b1, q, a[2]);
		byte_io(w[15:8], 1'b1, q, a[3]);
		stop_cond();
		ok = (a === 4'h0);
	endtask
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
		logic [7:0] q;
		logic       a;
		start_cond();
		byte_io({pri_pkg::BUS_ADDR, 1'b0}, 1'b1, q, a);
		byte_io(cmd, 1'b1, q, a);
		start_cond();
		byte_io({pri_pkg::BUS_ADDR, 1'b1}, 1'b1, q, a);
		byte_io(8'hff, 1'b0, w[7:0], a);
		byte_io(8'hff, 1'b1, w[15:8], a);
		stop_cond();
	endtask
endmodule

// file: verification/pri_readout_sva.sv
// port timing checks for the readout block
// assumes bus clock halves of at least four system cycles
`timescale 1ns/1ps
module pri_readout_sva #(
	parameter int unsigned P_LP_BASE_CYCLES = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_scl,
	input wire logic i_meas_valid,
	input wire logic i_cal_done,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic o_int_out,
	input wire logic o_int_oe,
	input wire logic o_meas_start
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_quiet;
		!o_meas_start [*8];
	endsequence
	sequence s_oe_held;
		$stable(o_sda_oe) [*7];
	endsequence
	sda_drive_a: assert property (o_sda_out == 1'b0)
		else $error("data drive value not low");
	int_drive_a: assert property (o_int_out == 1'b0)
		else $error("interrupt drive value not low");
	sda_change_a: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("data line changed while bus clock high");
	oe_stand_a: assert property ($changed(o_sda_oe) |=> s_oe_held)
		else $error("data line drive too short");
	int_rise_a: assert property ($rose(o_int_oe) |-> $past(i_meas_valid) || $past(i_cal_done))
		else $error("interrupt raised without a cause");
	int_fall_a: assert property ($fell(o_int_oe) |-> $past(i_meas_valid) || !i_scl)
		else $error("interrupt released without read or measurement");
	int_hold_a: assert property ((o_int_oe && !i_meas_valid && i_scl && $past(i_scl, 8))
		|=> o_int_oe) else $error("interrupt dropped while bus quiet");
	tick_pulse_a: assert property (o_meas_start |=> s_quiet)
		else $error("measurement request too long or too close");
endmodule
bind pri_readout pri_readout_sva #(.P_LP_BASE_CYCLES(P_LP_BASE_CYCLES)) i_sva (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_meas_valid(i_meas_valid),
	.i_cal_done(i_cal_done), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_int_out(o_int_out), .o_int_oe(o_int_oe), .o_meas_start(o_meas_start));

// file: verification/pri_readout_tb.sv
// self-checking bench for the readout block, host model on the bus pins
// assumes a pull-up on the data line and a short low-power base period
`timescale 1ns/1ps
module pri_readout_tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        scl, sda_low, sda_oe, sda_out, int_out, int_oe, meas_start;
	logic        meas_valid = 1'b0, cal_busy = 1'b0, cal_done = 1'b0, cal_sun = 1'b0;
	logic        protect = 1'b0;
	logic [11:0] meas_count = 12'h000, cal_data = 12'h000;
	int          mismatches = 0, tests_run = 0, cycles = 0, n;
	wire         sda = !(sda_low || sda_oe);
	always #10 clk = ~clk;
	pri_readout #(.P_LP_BASE_CYCLES(20)) i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_int_out(int_out),
		.o_int_oe(int_oe), .i_meas_valid(meas_valid), .i_meas_count(meas_count),
		.i_cal_busy(cal_busy), .i_cal_done(cal_done), .i_cal_sun(cal_sun),
		.i_cal_data(cal_data), .i_protect_entry(protect), .o_meas_start(meas_start));
	pri_host_model #(.P_QUARTER(2)) i_host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
		logic ok;
		i_host.write_word(cmd, w, ok);
		check("write ack", {15'h0, ok}, 16'h0001);
	endtask
	task automatic rdchk(input string name, input logic [7:0] cmd, input logic [15:0] exp);
		logic [15:0] w;
		i_host.read_word(cmd, w);
		check(name, w, exp);
	endtask
	task automatic pin(input logic exp);
		check("interrupt pin", {15'h0, int_oe}, {15'h0, exp});
	endtask
	task automatic meas(input logic [11:0] c);
		@(posedge clk);
		meas_valid <= 1'b1;
		meas_count <= c;
		@(posedge clk);
		meas_valid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic reset_dut();
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic setup(input logic [15:0] conf2);
		reset_dut();
		wr(pri_pkg::CMD_THDL, 16'h0100);
		wr(pri_pkg::CMD_THDH, 16'h0800);
		wr(pri_pkg::CMD_CONF2, conf2);
	endtask
	task automatic cal_finish();
		@(posedge clk);
		cal_done <= 1'b1;
		cal_busy <= 1'b0;
		cal_sun <= 1'b0;
		@(posedge clk);
		cal_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic next_tick(output int k);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (meas_start !== 1'b1 && k < 400);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		reset_dut();
		rdchk("count", pri_pkg::CMD_COUNT, 16'h0000);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0000);
		rdchk("config", pri_pkg::CMD_CONF2, 16'h0000);
		rdchk("unmapped", 8'h40, 16'h0000);
		rdchk("ident", pri_pkg::CMD_IDENT, {2'b00, pri_pkg::ADDR_OPTION, pri_pkg::VERSION,
			pri_pkg::DEVICE_CODE});
		meas(12'habc);
		wr(pri_pkg::CMD_COUNT, 16'h0123);
		rdchk("count", pri_pkg::CMD_COUNT, 16'h0abc);
		setup(16'h000c);
		meas(12'h050);
		pin(1'b1);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0100);
		meas(12'h900);
		pin(1'b1);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0200);
		pin(1'b0);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			meas(i == 0 ? 12'h800 : (i == 1 ? 12'h500 : 12'h100));
			pin(1'b0);
		end
		meas(12'h050);
		pin(1'b1);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0100);
		setup(16'h0008);
		meas(12'h050);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0000);
		meas(12'h900);
		meas(12'h500);
		meas(12'h500);
		pin(1'b1);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0200);
		meas(12'h050);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h0100);
		setup(16'h0004);
		meas(12'h7ff);
		pin(1'b0);
		meas(12'h800);
		pin(1'b1);
		meas(12'h100);
		pin(1'b1);
		meas(12'h0ff);
		pin(1'b0);
		setup(16'h003c);
		repeat (3) meas(12'h900);
		pin(1'b0);
		meas(12'h900);
		pin(1'b1);
		reset_dut();
		cal_busy <= 1'b1;
		cal_sun <= 1'b1;
		cal_data <= 12'h3a5;
		rdchk("calibration", pri_pkg::CMD_CAL, 16'hc000);
		cal_finish();
		@(posedge clk);
		protect <= 1'b1;
		@(posedge clk);
		protect <= 1'b0;
		pin(1'b0);
		rdchk("calibration", pri_pkg::CMD_CAL, 16'h43a5);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h3000);
		wr(pri_pkg::CMD_CONF4, 16'h0001);
		cal_finish();
		pin(1'b1);
		rdchk("flags", pri_pkg::CMD_FLAGS, 16'h2000);
		for (int code = 0; code < 4; code++)
		begin
			wr(pri_pkg::CMD_CONF4, {5'h00, code[1:0], 1'b1, 8'h00});
			next_tick(n);
			next_tick(n);
			next_tick(n);
			check("tick gap", n[15:0], 16'(20 << code));
		end
		summarize();
	end
endmodule
